// ===== hdl/tmc_timer.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
// Functional notes
// RL1: counter width is a parameter, built as 32-bit and 16-bit variants
// RL2: prescaler of counter width divides the count rate
// RL3: counter advances on system clock cycles gated by the prescaler
// RL4: four match values compared against running count
// RL5: match may flag an interrupt while counting continues
// RL6: stop-on-match halts counter, interrupt optional
// RL7: reset-on-match returns counter to zero, interrupt optional
// RL8: four outputs go low, high, toggle or hold on their match
// RL9: capture input edge copies count into capture register
// RL10: capture event can raise an interrupt when enabled
// RL11: selected capture edge clears counter and prescaler
// RL12: prescaler counts to limit, wraps, advances counter once
// RL13: event flags cleared by writing one; irq while enabled flag set
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input  logic                 sys_clk,
  input  logic                 resetn,
  input  logic                 ce,
  input  logic [ADDR_W-1:0]    addr,
  input  logic [DATA_W-1:0]    wdata,
  input  logic                 wr_stb,
  input  logic                 rd_stb,
  output logic [DATA_W-1:0]    rdata,
  input  logic                 cap_in,
  output logic [NUM_MATCH-1:0] ext_out,
  output logic                 irq
);

  logic [CTRL_W-1:0]    ctrl_r;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     pre_lim_r;
  logic [CNT_W-1:0]     pre_cnt_r;
  logic [CNT_W-1:0]     cap_r;
  logic [CNT_W-1:0]     match_r [NUM_MATCH];
  logic [MCTRL_W-1:0]   mctrl_r;
  logic [CCTRL_W-1:0]   cctrl_r;
  logic [ECTRL_W-1:0]   ectrl_r;
  logic [FLAG_W-1:0]    flags_r;
  logic [FLAG_W-1:0]    flags_nxt;
  logic [FLAG_W-1:0]    int_en;
  logic [DATA_W-1:0]    rdata_r;
  logic [DATA_W-1:0]    rdata_nxt;
  logic                 irq_r;
  logic                 cap_d_r;
  logic                 run;
  logic                 hold;
  logic                 pre_wrap;
  logic                 tick;
  logic                 cap_rise;
  logic                 cap_fall;
  logic                 cap_ev;
  logic                 cap_clr;
  logic                 ctrl_wr;
  logic                 cnt_wr;
  logic                 pre_lim_wr;
  logic                 mctrl_wr;
  logic                 cctrl_wr;
  logic                 ectrl_wr;
  logic                 ext_wr;
  logic                 fl_wr;
  logic                 match_wr;
  logic                 m_rst_any;
  logic                 m_stop_any;
  logic [NUM_MATCH-1:0] hit;
  logic [NUM_MATCH-1:0] m_rst;
  logic [NUM_MATCH-1:0] m_stop;
  logic [NUM_MATCH-1:0] m_int;
  logic [NUM_MATCH-1:0] ext_q;
  logic [IDX_MSB-IDX_LSB:0] m_idx;

  tmc_cnt_if #(.W(CNT_W)) cif ();

  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
    return ce & wr_stb & (addr == ofs);
  endfunction

  assign run        = ctrl_r[CTRL_RUN];
  assign hold       = ctrl_r[CTRL_HOLD];
  assign ctrl_wr    = wr_hit(OFS_CTRL);
  assign cnt_wr     = wr_hit(OFS_COUNT);
  assign pre_lim_wr = wr_hit(OFS_PRE_LIM);
  assign mctrl_wr   = wr_hit(OFS_MATCH_CTRL);
  assign cctrl_wr   = wr_hit(OFS_CAP_CTRL);
  assign ectrl_wr   = wr_hit(OFS_EXT_CTRL);
  assign ext_wr     = wr_hit(OFS_EXT_STATE);
  assign fl_wr      = wr_hit(OFS_FLAGS);
  assign m_idx      = addr[IDX_MSB:IDX_LSB];
  assign match_wr   = ce & wr_stb & (addr[PAGE_MSB:PAGE_LSB] == MATCH_PAGE)
                      & (addr[BYTE_MSB:0] == '0);

  // RL12 wrap at limit, also covers a limit lowered below the count
  assign pre_wrap = pre_cnt_r >= pre_lim_r;
  // RL3 count enable from prescaler
  assign tick     = ce & run & ~hold & pre_wrap;

  assign cap_rise = cap_in & ~cap_d_r;
  assign cap_fall = ~cap_in & cap_d_r;
  // RL9 capture edge select
  assign cap_ev   = ce & ((cap_rise & cctrl_r[CC_RISE]) | (cap_fall & cctrl_r[CC_FALL]));
  // RL11 clearing edge select
  assign cap_clr  = ce & cctrl_r[CC_CLR] & (cctrl_r[CC_CLR_FALL] ? cap_fall : cap_rise);

  assign cif.count = cnt_r;
  assign cif.tick  = tick;
  assign cif.ce    = ce;

  // RL4 four match channels
  for (genvar i = 0; i < NUM_MATCH; i++)
  begin : g_ch
    assign m_rst[i]  = hit[i] & mctrl_r[i * MC_W + MC_RST];
    assign m_stop[i] = hit[i] & mctrl_r[i * MC_W + MC_STOP];
    assign m_int[i]  = mctrl_r[i * MC_W + MC_INT];

    tmc_match_ch #(.CNT_W(CNT_W)) u_ch (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .cnt       (cif.dst),
      .match_val (match_r[i]),
      .action    (tmc_ext_e'(ectrl_r[i * EA_W +: EA_W])),
      .sw_we     (ext_wr),
      .sw_val    (wdata[i]),
      .hit       (hit[i]),
      .ext_out   (ext_q[i])
    );
  end

  assign m_rst_any  = |m_rst;
  assign m_stop_any = |m_stop;
  assign int_en     = {cctrl_r[CC_INT], m_int};

  // RL6 stop clears the run bit
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= '0;
    else if (ce)
    begin
      if (ctrl_wr)
        ctrl_r <= wdata[CTRL_W-1:0];
      else if (m_stop_any)
        ctrl_r[CTRL_RUN] <= 1'b0;
    end
  end

  // RL1 count register at variant width
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= '0;
    else if (ce)
    begin
      if (cnt_wr)
        cnt_r <= wdata[CNT_W-1:0];
      else if (cap_clr || hold)
        cnt_r <= '0;
      // RL7 reset on match
      else if (m_rst_any)
        cnt_r <= '0;
      // RL5 continuous count on match
      else if (tick && !m_stop_any)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  // RL2 prescaler counter
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      pre_cnt_r <= '0;
    else if (ce)
    begin
      if (cap_clr || hold)
        pre_cnt_r <= '0;
      else if (run)
        pre_cnt_r <= pre_wrap ? '0 : pre_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      pre_lim_r <= '0;
    else if (pre_lim_wr)
      pre_lim_r <= wdata[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mctrl_r <= '0;
      cctrl_r <= '0;
      ectrl_r <= '0;
    end
    else
    begin
      if (mctrl_wr)
        mctrl_r <= wdata[MCTRL_W-1:0];
      if (cctrl_wr)
        cctrl_r <= wdata[CCTRL_W-1:0];
      if (ectrl_wr)
        ectrl_r <= wdata[ECTRL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < NUM_MATCH; k++)
        match_r[k] <= '0;
    end
    else if (match_wr)
      match_r[m_idx] <= wdata[CNT_W-1:0];
  end

  // RL9 snapshot of the count
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_r   <= '0;
      cap_d_r <= 1'b0;
    end
    else if (ce)
    begin
      cap_d_r <= cap_in;
      if (cap_ev)
        cap_r <= cnt_r;
    end
  end

  // RL13 write one clears, set wins
  assign flags_nxt = (flags_r & ~(fl_wr ? wdata[FLAG_W-1:0] : '0)) | {cap_ev, hit};

  // RL10 capture and match flags
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags_r <= '0;
      irq_r   <= 1'b0;
    end
    else if (ce)
    begin
      flags_r <= flags_nxt;
      irq_r   <= |(flags_r & int_en);
    end
  end

  always_comb
  begin
    rdata_nxt = '0;
    case (addr)
      OFS_CTRL:       rdata_nxt = DATA_W'(ctrl_r);
      OFS_COUNT:      rdata_nxt = DATA_W'(cnt_r);
      OFS_PRE_LIM:    rdata_nxt = DATA_W'(pre_lim_r);
      OFS_PRE_CNT:    rdata_nxt = DATA_W'(pre_cnt_r);
      OFS_MATCH_CTRL: rdata_nxt = DATA_W'(mctrl_r);
      OFS_CAP_CTRL:   rdata_nxt = DATA_W'(cctrl_r);
      OFS_EXT_CTRL:   rdata_nxt = DATA_W'(ectrl_r);
      OFS_EXT_STATE:  rdata_nxt = DATA_W'(ext_q);
      OFS_FLAGS:      rdata_nxt = DATA_W'(flags_r);
      OFS_CAPTURE:    rdata_nxt = DATA_W'(cap_r);
      default:
      begin
        if (addr[PAGE_MSB:PAGE_LSB] == MATCH_PAGE && addr[BYTE_MSB:0] == '0)
          rdata_nxt = DATA_W'(match_r[m_idx]);
      end
    endcase
  end

  // read data in the cycle after an enabled strobe, held while ce is low, zero after any other enabled cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= '0;
    else if (ce)
      rdata_r <= rd_stb ? rdata_nxt : '0;
  end

  assign rdata   = rdata_r;
  assign ext_out = ext_q;
  assign irq     = irq_r;

  // RL12 prescaler wraps to zero
  presc_wrap_a: // RL12
    assert property (@(posedge sys_clk) disable iff (!resetn)
      tick |=> pre_cnt_r == '0)
    else $error("prescaler did not wrap");

  // RL3 count advances by one
  cnt_incr_a: // RL3
    assert property (@(posedge sys_clk) disable iff (!resetn)
      tick && !m_rst_any && !m_stop_any && !cnt_wr && !cap_clr
      |=> cnt_r == CNT_W'($past(cnt_r) + 1'b1))
    else $error("count did not advance on tick");

  // RL2 no advance between ticks
  cnt_hold_a: // RL2
    assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && !tick && !cnt_wr && !cap_clr && !hold |=> $stable(cnt_r))
    else $error("count moved without prescaler tick");

  // RL7 reset on match
  match_reset_a: // RL7
    assert property (@(posedge sys_clk) disable iff (!resetn)
      m_rst_any && !cnt_wr |=> cnt_r == '0)
    else $error("count not reset on match");

  // RL6 stop on match
  match_stop_a: // RL6
    assert property (@(posedge sys_clk) disable iff (!resetn)
      m_stop_any && !ctrl_wr && !m_rst_any && !cnt_wr && !cap_clr
      |=> !run && cnt_r == $past(cnt_r))
    else $error("counter kept running after stop match");

  // RL9 capture loads count
  cap_load_a: // RL9
    assert property (@(posedge sys_clk) disable iff (!resetn)
      cap_ev |=> cap_r == $past(cnt_r))
    else $error("capture register missed the count");

  // RL11 clear on capture edge
  cap_clear_a: // RL11
    assert property (@(posedge sys_clk) disable iff (!resetn)
      cap_clr && !cnt_wr |=> cnt_r == '0 && pre_cnt_r == '0)
    else $error("capture clear failed");

  // RL5 match flag set wins
  match_flag_a: // RL5
    assert property (@(posedge sys_clk) disable iff (!resetn)
      |hit |=> (flags_r[NUM_MATCH-1:0] & $past(hit)) == $past(hit))
    else $error("match flag not set");

  // RL10 capture interrupt path
  cap_irq_a: // RL10
    assert property (@(posedge sys_clk) disable iff (!resetn)
      cap_ev ##1 ce && int_en[FL_CAP] |=> irq_r)
    else $error("capture interrupt not raised");

  // RL13 irq drops with no enabled flag
  irq_idle_a: // RL13
    assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && (flags_r & int_en) == '0 |=> !irq_r)
    else $error("irq without enabled flag");

  read_idle_a:
    assert property (@(posedge sys_clk) disable iff (!resetn)
      ce && !rd_stb |=> rdata_r == '0)
    else $error("read data outside read cycle");

endmodule

// ===== hdl/tmc_pkg.sv
package tmc_pkg;

  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int NUM_MATCH = 4;
  localparam int FLAG_W    = NUM_MATCH + 1;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRE_LIM    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PRE_CNT    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MATCH_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP_CTRL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EXT_CTRL   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EXT_STATE  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE    = 8'h24;

  // match value page: 0x30 + 4 * index
  localparam logic [3:0] MATCH_PAGE = 4'h3;
  localparam int PAGE_LSB = 4;
  localparam int PAGE_MSB = 7;
  localparam int IDX_LSB  = 2;
  localparam int IDX_MSB  = 3;
  localparam int BYTE_MSB = 1;

  // control register
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_W    = 2;

  // per-match control field
  localparam int MC_INT  = 0;
  localparam int MC_RST  = 1;
  localparam int MC_STOP = 2;
  localparam int MC_W    = 3;
  localparam int MCTRL_W = NUM_MATCH * MC_W;

  // capture control
  localparam int CC_RISE     = 0;
  localparam int CC_FALL     = 1;
  localparam int CC_INT      = 2;
  localparam int CC_CLR      = 3;
  localparam int CC_CLR_FALL = 4;
  localparam int CCTRL_W     = 5;

  // external output action field
  localparam int EA_W    = 2;
  localparam int ECTRL_W = NUM_MATCH * EA_W;

  // flag bit of the capture event, match flags sit below it
  localparam int FL_CAP = NUM_MATCH;

  typedef enum logic [1:0] {
    EXT_NONE   = 2'b00,
    EXT_LOW    = 2'b01,
    EXT_HIGH   = 2'b10,
    EXT_TOGGLE = 2'b11
  } tmc_ext_e;

endpackage

// ===== hdl/tmc_cnt_if.sv
`timescale 1ns/1ps
interface tmc_cnt_if #(
  parameter int W = 32
);
  logic [W-1:0] count;
  logic         tick;
  logic         ce;

  modport src (output count, output tick, output ce);
  modport dst (input count, input tick, input ce);
endinterface

// ===== hdl/tmc_match_ch.sv
`timescale 1ns/1ps
module tmc_match_ch
  import tmc_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input  logic             sys_clk,
  input  logic             resetn,
  tmc_cnt_if.dst           cnt,
  input  logic [CNT_W-1:0] match_val,
  input  tmc_ext_e         action,
  input  logic             sw_we,
  input  logic             sw_val,
  output logic             hit,
  output logic             ext_out
);

  logic ext_r;

  // RL4 compare with count
  assign hit     = cnt.tick & (cnt.count == match_val);
  assign ext_out = ext_r;

  // RL8 pin action on match
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ext_r <= 1'b0;
    else if (cnt.ce)
    begin
      if (sw_we)
        ext_r <= sw_val;
      else if (hit)
      begin
        case (action)
          EXT_LOW:    ext_r <= 1'b0;
          EXT_HIGH:   ext_r <= 1'b1;
          EXT_TOGGLE: ext_r <= ~ext_r;
          default:    ext_r <= ext_r;
        endcase
      end
    end
  end

  // RL8 toggle check
  ext_toggle_a: // RL8
    assert property (@(posedge sys_clk) disable iff (!resetn)
      hit && action == EXT_TOGGLE && !sw_we |=> ext_out != $past(ext_out))
    else $error("match output did not toggle");

  // RL8 set and clear check
  ext_level_a: // RL8
    assert property (@(posedge sys_clk) disable iff (!resetn)
      hit && !sw_we && (action == EXT_HIGH || action == EXT_LOW)
      |=> ext_out == ($past(action) == EXT_HIGH))
    else $error("match output level wrong");

endmodule

// ===== tb/tmc_pin_model.sv
`timescale 1ns/1ps
module tmc_pin_model
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [7:0] width,
  input  wire logic [3:0] ext_out,
  output logic            cap_in,
  output logic [3:0]      ext_seen
);
  logic [7:0] left_r;

  // pulse generator: high for width cycles
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      left_r <= 8'h00;
      cap_in <= 1'b0;
    end
    else if (go)
    begin
      left_r <= width - 8'h01;
      cap_in <= 1'b1;
    end
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
    else
      cap_in <= 1'b0;
  end

  // sample the match pins as a load would
  always_ff @(posedge sys_clk)
  begin
    ext_seen <= ext_out;
  end
endmodule

// ===== tb/match_capture_counter_timer_tb.sv
`timescale 1ns/1ps
module match_capture_counter_timer_tb;
  import tmc_pkg::*;
  logic              sys_clk = 1'b0;
  logic              resetn  = 1'b0;
  logic              ce      = 1'b1;
  logic [ADDR_W-1:0] addr    = '0;
  logic [DATA_W-1:0] wdata   = '0;
  logic              wr_stb  = 1'b0;
  logic              rd_stb  = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rdata16;
  logic              cap_in;
  logic [3:0]        ext_out;
  logic [3:0]        ext_seen;
  logic              irq;
  logic              go      = 1'b0;
  logic [7:0]        width   = 8'h14;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  int                n_errors = 0;
  int                checks = 0;

  always #10 sys_clk = ~sys_clk;

  tmc_timer #(.CNT_W(32)) tmc_timer_inst (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cap_in(cap_in),
    .ext_out(ext_out), .irq(irq));

  // 16-bit variant sharing the bus, read data kept apart
  if (1)
  begin : g_w16
    tmc_timer #(.CNT_W(16)) tmc_timer_inst (
      .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata16), .cap_in(cap_in),
      .ext_out(), .irq());
  end

  tmc_pin_model tmc_pin_model_inst (
    .sys_clk(sys_clk), .resetn(resetn), .go(go), .width(width),
    .ext_out(ext_out), .cap_in(cap_in), .ext_seen(ext_seen));

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr   <= ad;
    wdata  <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] ad, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr   <= ad;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(8'hFC, a);
    chk("unmapped", 32'h0, a);
    // rate is clock over limit plus one
    wr(OFS_PRE_LIM, 32'h3);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_COUNT, a);
    repeat (38) @(posedge sys_clk);
    rd(OFS_COUNT, b);
    chk("count_rate", 32'hA, b - a);
    // four matches: toggle, high, low, none; stop on the last
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PRE_LIM, 32'h0);
    wr(OFS_COUNT, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(8'h30 + 8'(4 * i), 32'h4 + 32'(2 * i));
    wr(OFS_MATCH_CTRL, 32'h801);
    wr(OFS_EXT_CTRL, 32'h1B);
    wr(OFS_EXT_STATE, 32'hC);
    wr(OFS_FLAGS, 32'h1F);
    wr(OFS_CTRL, 32'h1);
    repeat (30) @(posedge sys_clk);
    rd(OFS_COUNT, a);
    chk("stop_count", 32'hA, a);
    rd(OFS_CTRL, a);
    chk("stop_run", 32'h0, a & 32'h1);
    chk("ext_out", 32'hB, {28'h0, ext_seen});
    rd(OFS_FLAGS, a);
    chk("match_flags", 32'hF, a);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(OFS_FLAGS, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    rd(OFS_FLAGS, a);
    chk("flag_w1c", 32'hE, a);
    // reset on match 1 wraps the count after six
    wr(OFS_MATCH_CTRL, 32'h10);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_FLAGS, 32'h1F);
    wr(OFS_CTRL, 32'h1);
    repeat (50) @(posedge sys_clk);
    rd(OFS_COUNT, a);
    chk("reset_count", 32'h2, a);
    rd(OFS_FLAGS, a);
    chk("reset_flags", 32'h3, a);
    // pulse width: clear on rise, capture on fall
    wr(OFS_CTRL, 32'h0);
    wr(OFS_MATCH_CTRL, 32'h0);
    wr(OFS_CAP_CTRL, 32'h0E);
    wr(OFS_COUNT, 32'h64);
    wr(OFS_FLAGS, 32'h1F);
    wr(OFS_CTRL, 32'h1);
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rd(OFS_CAPTURE, a);
    chk("capture", 32'h13, a);
    rd(OFS_FLAGS, a);
    chk("cap_flag", 32'h10, a & 32'h10);
    chk("cap_irq", 32'h1, {31'h0, irq});
    wr(OFS_CAPTURE, 32'h5);
    rd(OFS_CAPTURE, b);
    chk("capture_ro", 32'h13, b);
    // width variants truncate the count
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COUNT, 32'h1FFFF);
    rd(OFS_COUNT, a);
    chk("count32", 32'h1FFFF, a);
    chk("count16", 32'hFFFF, rdata16);
    // strobe lost while clock enable is low
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(OFS_COUNT, 32'h7);
    ce <= 1'b1;
    rd(OFS_COUNT, a);
    chk("ce_freeze", 32'h1FFFF, a);
    // hold keeps the count at zero
    wr(OFS_CTRL, 32'h3);
    rd(OFS_COUNT, a);
    chk("hold_zero", 32'h0, a);
    rd(8'h34, a);
    chk("match_val", 32'h6, a);
    conclude();
  end
endmodule
